/* src/dbgcs_cfg.svh */
// Command codes, field positions and reset values of the debug unit
`ifndef DBGCS_CFG_SVH
`define DBGCS_CFG_SVH
`define DBGCS_CMD_WR_CONFIG 8'h19
`define DBGCS_CMD_RD_CONFIG 8'h24
`define DBGCS_CMD_READ_STATUS 8'h30
`define DBGCS_CMD_SET_BP 8'h3f
`define DBGCS_CMD_HALT 8'h44
`define DBGCS_CMD_RESUME 8'h4c
`define DBGCS_CFG_RESET 8'h00
`define DBGCS_CFG_USED_MASK 8'h0f
`define DBGCS_CFG_TIMERS_OFF 3
`define DBGCS_CFG_DMA_HOLD 2
`define DBGCS_CFG_TIMER_FREEZE 1
`define DBGCS_CFG_INFO_PAGE 0
`define DBGCS_ST_ERASE_DONE 7
`define DBGCS_ST_CLK_GATED 6
`define DBGCS_ST_HALTED 5
`define DBGCS_ST_ACTIVE_MODE 4
`define DBGCS_ST_HALT_CAUSE 3
`define DBGCS_ST_LOCKED 2
`define DBGCS_ST_OSC_STABLE 1
`define DBGCS_ST_STACK_OVF 0
`define DBGCS_BP_SLOT_HI 4
`define DBGCS_BP_SLOT_LO 3
`define DBGCS_BP_ENABLE 2
`define DBGCS_STACK_ADDR 8'hff
`define DBGCS_PM_ACTIVE 2'h0
`define DBGCS_PM_LIGHT 2'h1
`define DBGCS_SET_BP_DATA 2'h3
`endif

/* src/dbgcs_pkg.sv */
// Types shared by the debug configuration, status and breakpoint unit
package dbgcs_pkg;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [7:0] data2;
  } dbgcs_cmd_s;
  typedef struct packed {
    logic [17:0] code_addr;
    logic data_wr;
    logic [7:0] data_addr;
    logic clock_gated;
    logic inject_instruction_cmd;
    logic step_branch;
    logic wake;
  } dbgcs_cpu_s;
  typedef struct packed {
    logic [1:0] power_mode;
    logic crystal_stable_flag;
    logic rc_stable_flag;
    logic erase_busy;
    logic debug_lock_setting;
  } dbgcs_sys_s;
  typedef enum logic [1:0] {
    DBGCS_L_CMD,
    DBGCS_L_DATA,
    DBGCS_L_WAIT
  } dbgcs_link_e;
endpackage

/* src/dbgcs_unit.sv */
// Debug configuration byte, status byte, breakpoints and power-mode handling
`timescale 1ns/1ps
`default_nettype none
`include "dbgcs_cfg.svh"
module dbgcs_unit #(
  parameter int BP_COUNT = 4,
  parameter int ADDR_W = 18
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic link_byte_valid_in,
  input wire logic [7:0] link_byte_in,
  output logic link_resp_valid_out,
  output logic [7:0] link_resp_byte_out,
  output logic link_busy_out,
  input wire dbgcs_pkg::dbgcs_cpu_s cpu_in,
  input wire dbgcs_pkg::dbgcs_sys_s sys_in,
  output logic cpu_halt_out,
  output logic timers_stop_out,
  output logic timer_hold_out,
  output logic dma_pause_out,
  output logic info_page_select_out,
  output logic regulator_keep_on_out
);
  import dbgcs_pkg::*;

  // ---------------- Link domain: byte assembly ----------------
  dbgcs_link_e link_state_q;
  dbgcs_cmd_s link_cmd_q;
  logic [1:0] link_left_q;
  logic link_req_tgl_q;
  logic [2:0] link_ack_sync_q;
  logic ack_tgl_q;
  logic [7:0] ack_byte_q;

  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      link_state_q <= DBGCS_L_CMD;
      link_cmd_q <= '0;
      link_left_q <= 2'h0;
      link_req_tgl_q <= 1'b0;
    end else begin
      case (link_state_q)
        DBGCS_L_CMD: begin
          if (link_byte_valid_in) begin
            link_cmd_q <= '{code: link_byte_in, default: 8'h00};
            if (link_byte_in == `DBGCS_CMD_SET_BP) begin
              link_left_q <= `DBGCS_SET_BP_DATA;
              link_state_q <= DBGCS_L_DATA;
            end else if (link_byte_in == `DBGCS_CMD_WR_CONFIG) begin
              link_left_q <= 2'h1;
              link_state_q <= DBGCS_L_DATA;
            end else begin
              link_req_tgl_q <= ~link_req_tgl_q;
              link_state_q <= DBGCS_L_WAIT;
            end
          end
        end
        DBGCS_L_DATA: begin
          if (link_byte_valid_in) begin
            // Bytes shift in at data2; the first of three ends in data0, a lone byte stays in data2
            link_cmd_q.data0 <= link_cmd_q.data1;
            link_cmd_q.data1 <= link_cmd_q.data2;
            link_cmd_q.data2 <= link_byte_in;
            link_left_q <= link_left_q - 2'h1;
            if (link_left_q == 2'h1) begin
              link_req_tgl_q <= ~link_req_tgl_q;
              link_state_q <= DBGCS_L_WAIT;
            end
          end
        end
        DBGCS_L_WAIT: begin
          // Bytes sent while waiting are dropped
          if (link_ack_sync_q[2] != link_ack_sync_q[1]) begin
            link_state_q <= DBGCS_L_CMD;
          end
        end
        default: link_state_q <= DBGCS_L_CMD;
      endcase
    end
  end

  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      link_ack_sync_q <= 3'h0;
    end else begin
      link_ack_sync_q <= {link_ack_sync_q[1:0], ack_tgl_q};
    end
  end

  // Answer byte is written with the toggle and stays stable while it synchronises, safe to sample
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      link_resp_valid_out <= 1'b0;
      link_resp_byte_out <= 8'h00;
      link_busy_out <= 1'b0;
    end else begin
      link_resp_valid_out <= link_ack_sync_q[2] != link_ack_sync_q[1];
      if (link_ack_sync_q[2] != link_ack_sync_q[1]) begin
        link_resp_byte_out <= ack_byte_q;
      end
      link_busy_out <= link_state_q == DBGCS_L_WAIT &&
                       link_ack_sync_q[2] == link_ack_sync_q[1];
    end
  end

  // ---------------- System domain ----------------
  logic [2:0] req_sync_q;
  logic req_new;
  dbgcs_cmd_s cmd;
  logic cmd_ok;
  logic [7:0] cfg_q;
  logic halted_q;
  logic halt_cause_q;
  logic stack_ovf_q;
  logic attached_q;
  logic [1:0] last_mode_q;
  logic [BP_COUNT-1:0] bp_en_q;
  logic [ADDR_W-1:0] bp_addr_q [BP_COUNT];
  logic [BP_COUNT-1:0] bp_hit;
  logic [7:0] status;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_sync_q <= 3'h0;
    end else begin
      req_sync_q <= {req_sync_q[1:0], link_req_tgl_q};
    end
  end

  // Command word stays frozen until acknowledged
  assign req_new = req_sync_q[2] != req_sync_q[1];
  assign cmd = link_cmd_q;
  // unit refuses all but status polling while debug_lock_setting is low
  assign cmd_ok = req_new && (sys_in.debug_lock_setting ||
                  cmd.code == `DBGCS_CMD_READ_STATUS);

  always_comb begin
    status = 8'h00;
    status[`DBGCS_ST_ERASE_DONE] = ~sys_in.erase_busy;
    status[`DBGCS_ST_CLK_GATED] = cpu_in.clock_gated;
    status[`DBGCS_ST_HALTED] = halted_q;
    status[`DBGCS_ST_ACTIVE_MODE] = sys_in.power_mode == `DBGCS_PM_ACTIVE;
    status[`DBGCS_ST_HALT_CAUSE] = halt_cause_q;
    status[`DBGCS_ST_LOCKED] = sys_in.debug_lock_setting;
    status[`DBGCS_ST_OSC_STABLE] = sys_in.crystal_stable_flag & sys_in.rc_stable_flag;
    status[`DBGCS_ST_STACK_OVF] = stack_ovf_q;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_tgl_q <= 1'b0;
      ack_byte_q <= 8'h00;
    end else if (req_new) begin
      ack_tgl_q <= ~ack_tgl_q;
      if (cmd_ok && cmd.code == `DBGCS_CMD_RD_CONFIG) begin
        ack_byte_q <= cfg_q;
      end else begin
        ack_byte_q <= status;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_q <= `DBGCS_CFG_RESET;
    end else if (cmd_ok && cmd.code == `DBGCS_CMD_WR_CONFIG) begin
      // configuration write; upper bits held at zero anyway
      cfg_q <= cmd.data2 & `DBGCS_CFG_USED_MASK;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BP_COUNT; gi++) begin : g_bp
      always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          bp_en_q[gi] <= 1'b0;
          bp_addr_q[gi] <= '0;
        end else if (cmd_ok && cmd.code == `DBGCS_CMD_SET_BP &&
                     cmd.data0[`DBGCS_BP_SLOT_HI:`DBGCS_BP_SLOT_LO] == 2'(gi)) begin
          bp_en_q[gi] <= cmd.data0[`DBGCS_BP_ENABLE];
          bp_addr_q[gi] <= {cmd.data0[1:0], cmd.data1, cmd.data2};
        end
      end
      assign bp_hit[gi] = bp_en_q[gi] && bp_addr_q[gi] == cpu_in.code_addr;
    end
  endgenerate

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      halted_q <= 1'b0;
      halt_cause_q <= 1'b0;
    end else if (cmd_ok && cmd.code == `DBGCS_CMD_HALT) begin
      halted_q <= 1'b1;
      halt_cause_q <= 1'b0;
    end else if (cmd_ok && cmd.code == `DBGCS_CMD_RESUME && halted_q) begin
      halted_q <= 1'b0;
    end else if (!halted_q && |bp_hit) begin
      halted_q <= 1'b1;
      halt_cause_q <= 1'b1;
    end else if (attached_q && cpu_in.wake &&
                 last_mode_q != `DBGCS_PM_ACTIVE && last_mode_q != `DBGCS_PM_LIGHT) begin
      // stop after deep wake; light sleep excluded
      halted_q <= 1'b1;
    end
  end

  // Mode held from before wake, as wake resets the mode bits
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      last_mode_q <= `DBGCS_PM_ACTIVE;
    end else if (!cpu_in.wake) begin
      last_mode_q <= sys_in.power_mode;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      attached_q <= 1'b0;
    end else if (cmd_ok) begin
      attached_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stack_ovf_q <= 1'b0;
    end else if (cpu_in.data_wr && cpu_in.data_addr == `DBGCS_STACK_ADDR) begin
      stack_ovf_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cpu_halt_out <= 1'b0;
      timers_stop_out <= 1'b0;
      timer_hold_out <= 1'b0;
      dma_pause_out <= 1'b0;
      info_page_select_out <= 1'b0;
      regulator_keep_on_out <= 1'b0;
    end else begin
      cpu_halt_out <= halted_q;
      timers_stop_out <= cfg_q[`DBGCS_CFG_TIMERS_OFF];
      timer_hold_out <= cfg_q[`DBGCS_CFG_TIMERS_OFF] ||
                        (cfg_q[`DBGCS_CFG_TIMER_FREEZE] &&
                         (cpu_in.inject_instruction_cmd || cpu_in.step_branch));
      dma_pause_out <= cfg_q[`DBGCS_CFG_DMA_HOLD];
      info_page_select_out <= cfg_q[`DBGCS_CFG_INFO_PAGE];
      regulator_keep_on_out <= attached_q;
    end
  end
endmodule
`default_nettype wire

/* test/dbgcs_checker.sv */
// Port-level assertions for the debug unit
`timescale 1ns/1ps
`default_nettype none
module dbgcs_checker (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic link_byte_valid_in,
  input wire logic [7:0] link_byte_in,
  input wire logic link_resp_valid_out,
  input wire logic [7:0] link_resp_byte_out,
  input wire logic link_busy_out,
  input wire dbgcs_pkg::dbgcs_cpu_s cpu_in,
  input wire dbgcs_pkg::dbgcs_sys_s sys_in,
  input wire logic cpu_halt_out,
  input wire logic timers_stop_out,
  input wire logic timer_hold_out,
  input wire logic dma_pause_out,
  input wire logic info_page_select_out,
  input wire logic regulator_keep_on_out
);
  import dbgcs_pkg::*;
  AST_STOP_HOLD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    timers_stop_out && $past(timers_stop_out) |-> timer_hold_out) else $error("hold low");
  AST_FREEZE_CAUSE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    timer_hold_out && !timers_stop_out && !$past(timers_stop_out) && !$past(timers_stop_out, 2)
    |-> $past(cpu_in.inject_instruction_cmd || cpu_in.step_branch)
    || $past(cpu_in.inject_instruction_cmd || cpu_in.step_branch, 2)) else $error("hold without cause");
  AST_REG_KEEP: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    regulator_keep_on_out |=> regulator_keep_on_out) else $error("regulator dropped");
  AST_CFG_NEEDS_CMD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    dma_pause_out || info_page_select_out || timers_stop_out
    |-> ##[0:4] regulator_keep_on_out) else $error("config without command");
  AST_LIGHT_WAKE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    cpu_in.wake && $past(sys_in.power_mode) == 2'h1 && !cpu_halt_out |-> ##3 !cpu_halt_out)
    else $error("light wake halted");
  AST_RESP_PULSE: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    link_resp_valid_out |=> !link_resp_valid_out) else $error("answer too long");
  AST_RESP_HOLD: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    !link_resp_valid_out |-> $stable(link_resp_byte_out)) else $error("answer byte moved");
  AST_BUSY_BOUND: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    $rose(link_busy_out) |-> ##[1:30] !link_busy_out) else $error("busy stuck");
  COV_HALT: cover property (@(posedge sys_clk_in) $rose(cpu_halt_out));
  COV_HOLD: cover property (@(posedge sys_clk_in) timer_hold_out && !timers_stop_out);
  COV_RESP: cover property (@(posedge link_clk_in) link_resp_valid_out);
endmodule
bind dbgcs_unit dbgcs_checker i_dbgcs_checker (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .link_clk_in(link_clk_in), .link_byte_valid_in(link_byte_valid_in), .link_byte_in(link_byte_in),
  .link_resp_valid_out(link_resp_valid_out), .link_resp_byte_out(link_resp_byte_out),
  .link_busy_out(link_busy_out), .cpu_in(cpu_in), .sys_in(sys_in), .cpu_halt_out(cpu_halt_out),
  .timers_stop_out(timers_stop_out), .timer_hold_out(timer_hold_out),
  .dma_pause_out(dma_pause_out), .info_page_select_out(info_page_select_out),
  .regulator_keep_on_out(regulator_keep_on_out));
`default_nettype wire

/* test/dbgcs_host.sv */
// Debug host model: gated link clock, byte sender, answer catcher
`timescale 1ns/1ps
`default_nettype none
module dbgcs_host (
  output logic link_clk_out,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_byte_in
);
  import dbgcs_pkg::*;
  logic run = 1'b1;
  // Clock stands still between commands
  initial begin
    link_clk_out = 1'b0;
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
    #1;
    forever #3 if (run) link_clk_out = ~link_clk_out;
  end
  // command byte then all its data bytes
  task automatic cmd(input dbgcs_pkg::dbgcs_cmd_s c, input int n, output logic [7:0] resp,
    output bit ok);
    logic [31:0] v;
    v = c;
    ok = 1'b0;
    run = 1'b1;
    repeat (3) @(negedge link_clk_out);
    for (int i = 0; i < n; i++) begin
      byte_valid_out = 1'b1;
      byte_out = v[31-8*i -: 8];
      @(negedge link_clk_out);
    end
    byte_valid_out = 1'b0;
    // Released line shows no stale byte
    byte_out = ~byte_out;
    for (int k = 0; k < 40 && !ok; k++) begin
      @(posedge link_clk_out);
      if (resp_valid_in) begin
        ok = 1'b1;
        resp = resp_byte_in;
      end
    end
    @(negedge link_clk_out);
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/dbgcs_unit_test.sv */
// Self-checking bench for the debug configuration, status and breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module dbgcs_unit_test;
  import dbgcs_pkg::*;
  logic sys_clk_in, sys_rst_in, lclk, bv, halt, hold, stop, dma, info, reg_on, rv, busy, ovf;
  logic [7:0] bb, rb, r;
  logic [7:0] exp_o [4] = '{8'h03, 8'h01, 8'h05, 8'h19};
  dbgcs_cpu_s cpu;
  dbgcs_sys_s sys;
  int error_cnt = 0;
  int checked = 0;
  bit ok;
  dbgcs_unit i_dbgcs_unit (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(lclk),
    .link_byte_valid_in(bv), .link_byte_in(bb), .link_resp_valid_out(rv), .link_resp_byte_out(rb),
    .link_busy_out(busy), .cpu_in(cpu), .sys_in(sys), .cpu_halt_out(halt), .timers_stop_out(stop),
    .timer_hold_out(hold), .dma_pause_out(dma), .info_page_select_out(info),
    .regulator_keep_on_out(reg_on));
  dbgcs_host i_dbgcs_host (.link_clk_out(lclk), .byte_valid_out(bv), .byte_out(bb),
    .resp_valid_in(rv), .resp_byte_in(rb));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [7:0] st(input logic h, input logic c);
    st = {~sys.erase_busy, cpu.clock_gated, h, sys.power_mode == 2'h0, c, sys.debug_lock_setting,
      sys.crystal_stable_flag & sys.rc_stable_flag, ovf};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Empty name: answer not compared
  task automatic xfer(input logic [31:0] c, input int n, input logic [7:0] e, input string w);
    i_dbgcs_host.cmd(c, n, r, ok);
    // Back onto a system falling edge; link edges can meet system rising edges
    cyc(1);
    if (!ok) begin
      error_cnt++;
      finish_test();
    end
    if (w != "") chk(w, e, r);
  endtask
  task automatic hit(input logic [17:0] a, input logic e);
    cpu.code_addr = a;
    cyc(1);
    cpu.code_addr = 18'h0;
    cyc(3);
    chk("bp halt", {7'h0, e}, {7'h0, halt});
    if (e) begin
      xfer({8'h30, 24'h0}, 1, st(1, 1), "bp status");
      xfer({8'h4c, 24'h0}, 1, 0, "");
    end
  endtask
  initial begin
    sys_rst_in = 1'b1;
    cpu = '0;
    sys = '0;
    ovf = 1'b0;
    sys.crystal_stable_flag = 1'b1;
    sys.rc_stable_flag = 1'b1;
    cyc(8);
    sys_rst_in = 1'b0;
    cyc(2);
    chk("outs", 8'h00, {2'h0, halt, stop, hold, dma, info, reg_on});
    xfer({8'h19, 8'h0f, 16'h0}, 2, st(0, 0), "locked wr");
    xfer({8'h24, 24'h0}, 1, st(0, 0), "locked rd");
    chk("outs", 8'h00, {2'h0, halt, stop, hold, dma, info, reg_on});
    sys.debug_lock_setting = 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer({8'h19, 8'h01 << i, 16'h0}, 2, st(0, 0), "cfg wr");
      xfer({8'h24, 24'h0}, 1, 8'h01 << i, "cfg rd");
      cyc(2);
      chk("outs", exp_o[i], {2'h0, halt, stop, hold, dma, info, reg_on});
    end
    for (int j = 0; j < 3; j++) begin
      xfer({8'h19, (j < 2) ? 8'h02 : 8'h00, 16'h0}, 2, 0, "");
      cpu.inject_instruction_cmd = (j != 1);
      cpu.step_branch = (j == 1);
      cyc(2);
      chk("freeze", {7'h0, j < 2}, {7'h0, hold});
      cpu.inject_instruction_cmd = 1'b0;
      cpu.step_branch = 1'b0;
      cyc(3);
      chk("thaw", 8'h00, {7'h0, hold});
    end
    sys.erase_busy = 1'b1;
    cpu.clock_gated = 1'b1;
    sys.power_mode = 2'h2;
    sys.crystal_stable_flag = 1'b0;
    cpu.data_addr = 8'hff;
    cpu.data_wr = 1'b1;
    cyc(1);
    cpu.data_wr = 1'b0;
    ovf = 1'b1;
    xfer({8'h30, 24'h0}, 1, st(0, 0), "status");
    sys = 6'h07;
    cpu.clock_gated = 1'b0;
    cpu.data_addr = 8'hfe;
    cpu.data_wr = 1'b1;
    cyc(1);
    cpu.data_wr = 1'b0;
    xfer({8'h4c, 24'h0}, 1, st(0, 0), "resume idle");
    xfer({8'h44, 24'h0}, 1, 0, "");
    xfer({8'h30, 24'h0}, 1, st(1, 0), "halted");
    xfer({8'h4c, 24'h0}, 1, 0, "");
    xfer({8'h30, 24'h0}, 1, st(0, 0), "resumed");
    xfer({8'h55, 8'h00, 16'h0}, 2, st(0, 0), "inject");
    xfer({8'h3f, 8'h16, 8'h12, 8'h34}, 4, 0, "");
    xfer({8'h3f, 8'h1d, 8'h12, 8'h34}, 4, 0, "");
    hit(18'h2_1234, 1'b1);
    hit(18'h1_1234, 1'b1);
    xfer({8'h3f, 8'h12, 8'h12, 8'h34}, 4, 0, "");
    hit(18'h2_1234, 1'b0);
    sys.power_mode = 2'h1;
    // Mode must settle before the wake pulse, the unit keys on the prior mode
    cyc(2);
    cpu.wake = 1'b1;
    cyc(1);
    cpu.wake = 1'b0;
    cyc(3);
    chk("light wake", 8'h00, {7'h0, halt});
    sys.power_mode = 2'h2;
    cyc(2);
    cpu.wake = 1'b1;
    cyc(1);
    cpu.wake = 1'b0;
    cyc(3);
    chk("deep wake", 8'h01, {7'h0, halt});
    xfer({8'h44, 24'h0}, 1, 0, "");
    xfer({8'h4c, 24'h0}, 1, 0, "");
    cyc(3);
    chk("run again", 8'h01, {6'h0, halt, reg_on});
    finish_test();
  end
endmodule
`default_nettype wire
